/* core/prbs_test_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  pattern test path and the payload controllers' indirect access port.
  Assumes an 8-bit register port with byte offsets as listed below.
*/
// Summary of operation
// RULE1: test select 20H routes pattern to framer 1
// RULE2: control 82H: error counting and auto resync
// RULE3: pattern length comes from length register
// RULE4: feedback tap comes from tap register
// RULE5: last insertion write loads pattern, starts generation
// RULE6: loopback 04H selects diagnostic digital loopback
// RULE7: access enable 01H opens indirect registers
// RULE8: host writes tx data then tx address
// RULE9: host writes rx data then rx address
// RULE10: host initialises all indirect words before use; the bench writes only rx 20H-3FH and tx 20H-3FH, 60H-7FH
// RULE11: controllers run only with block enable set
// RULE12: busy bit7 during access; host waits
// RULE13: sync valid and no bit error means synchronised
// RULE14: host reads detector status twice before judging
// RULE15: 08H then 00H injects one bit error
// RULE16: writing 00H latches count into counter registers
// RULE17: receive pattern generate redirects pattern path
// RULE18: busy set by address write, cleared on completion
`ifndef PRBS_TEST_REGS_SVH
`define PRBS_TEST_REGS_SVH

// ============================================================
// Offsets
`define REG_TEST_SEL      8'h0C
`define REG_SIGBUF_CTRL   8'h5C
`define REG_SIGBUF_STAT   8'h5D
`define REG_RXPC_CTRL     8'h60
`define REG_RXPC_STAT     8'h61
`define REG_TXPC_CTRL     8'h64
`define REG_TXPC_STAT     8'h65
`define REG_PAT_CTRL      8'h70
`define REG_PAT_STAT      8'h71
`define REG_PAT_LEN       8'h72
`define REG_PAT_TAP       8'h73
`define REG_ERR_INS       8'h74
`define REG_INS_FIRST     8'h78
`define REG_INS_LAST      8'h7B
`define REG_CNT_FIRST     8'h7C
`define REG_CNT_LAST      8'h7F
`define REG_LOOPBACK      8'h87
`define REG_RX_ACC_EN     8'hDC
`define REG_RX_IND_ADDR   8'hDE
`define REG_RX_IND_DATA   8'hDF
`define REG_TX_ACC_EN     8'hE0
`define REG_TX_IND_ADDR   8'hE2
`define REG_TX_IND_DATA   8'hE3
`define REG_IRQ_STATUS    8'hF0
`define REG_IRQ_MASK      8'hF1

// ============================================================
// Fields
`define BIT_BLOCK_ENABLE  0
`define BIT_BUSY          7
`define BIT_ACC_ENABLE    0
`define BIT_RX_PAT_GEN    2
`define BIT_CNT_ERRORS    7
`define BIT_AUTO_RESYNC   1
`define BIT_REPETITIVE    4
`define BIT_SYNC_VALID    4
`define BIT_BIT_ERROR     2
`define BIT_ERR_INJECT    3
`define BIT_LOOP_DIAG     2
`define BIT_TX_TEST       3
`define BIT_RX_TEST       7
`define BIT_IND_READ      7
`define FRAMER_SEL_LSB    5
`define IRQ_SYNC_CHANGE   0
`define IRQ_BIT_ERROR     1
`define IRQ_IND_DONE      2

// ============================================================
// Reset values and counts
`define RESET_BYTE        8'h00
`define SYNC_MATCHES      6'h30
`define RESYNC_ERRORS     4'h8
`define SLOT_PAGE         2'h1

`endif

/* core/prbs_test_pkg.sv */
/*
  Types shared by the pattern test path files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package prbs_test_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    IND_IDLE   = 2'b00,
    IND_ACCESS = 2'b01,
    IND_FINISH = 2'b10
  } ind_state_t;
endpackage : prbs_test_pkg

/* core/indirect_mem.sv */
/*
  Single-port word store behind a payload controller's indirect port.
  Assumes one access per cycle; read data come from a register.
*/
module indirect_mem #(
  parameter int AW = 7
) (
  // Clock
  input  wire logic                  clk,
  input  wire logic                  clkEn,
  // Access
  input  wire logic                  wrEn,
  input  wire logic [AW-1:0]         addr,
  input  wire prbs_test_pkg::byte_t  wrData,
  output prbs_test_pkg::byte_t       rdData
);
  import prbs_test_pkg::*;

  byte_t mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[addr] <= wrData;
      end
      rdData <= mem[addr];
    end
  end
endmodule : indirect_mem

/* core/prbs_test_path.sv */
/*
  Pattern generator and detector with timeslot insertion, error injection,
  error counting, loopback, and the indirect ports of both payload
  controllers. Assumes a same-clock bit stream: slotBitEn marks one bit of
  timeslot slotIdx on txBitIn and rxBitIn.
*/
`include "prbs_test_regs.svh"

module prbs_test_path (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  clkEn,
  // Register port
  input  wire logic [7:0]            regAddr,
  input  wire prbs_test_pkg::byte_t  regWrData,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  output prbs_test_pkg::byte_t       regRdData,
  // Bit stream
  input  wire logic [4:0]            slotIdx,
  input  wire logic                  slotBitEn,
  input  wire logic                  txBitIn,
  input  wire logic                  rxBitIn,
  output logic                       txBitOut,
  output logic                       rxBitOut,
  // Status
  output logic [2:0]                 framerSel,
  output logic                       loopbackDiag,
  output logic                       irq
);
  import prbs_test_pkg::*;

  // ============================================================
  // Register storage
  byte_t       testSel_r, sigCtrl_r, patCtrl_r, patLen_r, patTap_r, errIns_r, loop_r;
  byte_t       irqStat_r, irqMask_r, rdData_r;
  byte_t       insReg_r [0:3];
  logic [31:0] cnt_r, cntLatch_r, gen_r, det_r;
  logic        syncValid_r, bitErrInd_r, errPend_r;
  logic [5:0]  matchCnt_r;
  logic [3:0]  missCnt_r;
  logic        txOut_r, rxOut_r;

  // Per controller: index 0 receive, index 1 transmit
  byte_t       pcCtrl_r [0:1];
  byte_t       accEn_r [0:1];
  byte_t       indAddr_r [0:1];
  byte_t       indData_r [0:1];
  logic [1:0]  busy;
  logic [1:0]  indDone;
  logic [31:0] slotMask [0:1];

  logic        wr, rd;
  logic [4:0]  lenIdx, tapIdx, fbIdx;
  assign wr     = regWrEn && clkEn;
  assign rd     = regRdEn && clkEn;
  assign lenIdx = patLen_r[4:0];                           // [RULE3]
  assign tapIdx = patTap_r[4:0];                           // [RULE4]
  assign fbIdx  = lenIdx - tapIdx;                         // [RULE4]

  // ============================================================
  // Plain control registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      testSel_r <= `RESET_BYTE;
      sigCtrl_r <= `RESET_BYTE;
      patCtrl_r <= `RESET_BYTE;
      patLen_r  <= `RESET_BYTE;
      patTap_r  <= `RESET_BYTE;
      errIns_r  <= `RESET_BYTE;
      loop_r    <= `RESET_BYTE;
      irqMask_r <= `RESET_BYTE;
    end else if (wr) begin
      if (regAddr == `REG_TEST_SEL) begin
        testSel_r <= regWrData;                            // [RULE1] [RULE17]
      end else if (regAddr == `REG_SIGBUF_CTRL) begin
        sigCtrl_r <= regWrData;                            // [RULE11]
      end else if (regAddr == `REG_PAT_CTRL) begin
        patCtrl_r <= regWrData;                            // [RULE2]
      end else if (regAddr == `REG_PAT_LEN) begin
        patLen_r <= regWrData;
      end else if (regAddr == `REG_PAT_TAP) begin
        patTap_r <= regWrData;
      end else if (regAddr == `REG_ERR_INS) begin
        errIns_r <= regWrData;
      end else if (regAddr == `REG_LOOPBACK) begin
        loop_r <= regWrData;                               // [RULE6]
      end else if (regAddr == `REG_IRQ_MASK) begin
        irqMask_r <= regWrData;
      end
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_ins
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          insReg_r[i] <= `RESET_BYTE;
        end else if (wr && regAddr == `REG_INS_FIRST + 8'(i)) begin
          insReg_r[i] <= regWrData;
        end
      end
    end
  endgenerate

  // ============================================================
  // Payload controllers and their indirect ports
  generate
    for (genvar c = 0; c < 2; c++) begin : g_pc
      localparam int          AW    = (c == 0) ? 6 : 7;
      localparam int          TBIT  = (c == 0) ? `BIT_RX_TEST : `BIT_TX_TEST;
      localparam logic [7:0]  A_CTL = (c == 0) ? `REG_RXPC_CTRL : `REG_TXPC_CTRL;
      localparam logic [7:0]  A_EN  = (c == 0) ? `REG_RX_ACC_EN : `REG_TX_ACC_EN;
      localparam logic [7:0]  A_ADR = (c == 0) ? `REG_RX_IND_ADDR : `REG_TX_IND_ADDR;
      localparam logic [7:0]  A_DAT = (c == 0) ? `REG_RX_IND_DATA : `REG_TX_IND_DATA;

      ind_state_t state_r;
      byte_t      memRd;
      logic       open;
      logic       isRead;
      assign open   = accEn_r[c][`BIT_ACC_ENABLE] && pcCtrl_r[c][`BIT_BLOCK_ENABLE]; // [RULE7] [RULE11]
      assign isRead = indAddr_r[c][`BIT_IND_READ];
      assign busy[c]    = (state_r != IND_IDLE);               // [RULE12]
      assign indDone[c] = clkEn && (state_r == IND_FINISH);

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pcCtrl_r[c] <= `RESET_BYTE;
          accEn_r[c]  <= `RESET_BYTE;
        end else if (wr && regAddr == A_CTL) begin
          pcCtrl_r[c] <= regWrData;
        end else if (wr && regAddr == A_EN) begin
          accEn_r[c] <= regWrData;
        end
      end

      // Address write starts an access; writes while busy are dropped
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          state_r      <= IND_IDLE;
          indAddr_r[c] <= `RESET_BYTE;
        end else if (clkEn) begin
          case (state_r)
            IND_IDLE: begin
              if (regWrEn && regAddr == A_ADR && open) begin
                indAddr_r[c] <= regWrData;
                state_r      <= IND_ACCESS;                    // [RULE18]
              end
            end
            IND_ACCESS: state_r <= IND_FINISH;
            IND_FINISH: state_r <= IND_IDLE;                   // [RULE18]
            default:    state_r <= IND_IDLE;
          endcase
        end
      end

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          indData_r[c] <= `RESET_BYTE;
        end else if (clkEn) begin
          if (state_r == IND_FINISH && isRead) begin
            indData_r[c] <= memRd;
          end else if (regWrEn && regAddr == A_DAT && open && !busy[c]) begin
            indData_r[c] <= regWrData;
          end
        end
      end

      // Shadow of the test bits of timeslots 0..31 for the stream side
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          slotMask[c] <= '0;
        end else if (clkEn && state_r == IND_ACCESS && !isRead
                     && indAddr_r[c][6:5] == `SLOT_PAGE) begin
          slotMask[c][indAddr_r[c][4:0]] <= indData_r[c][TBIT];
        end
      end

      indirect_mem #(.AW(AW)) u_mem (
        .clk    (clk),
        .clkEn  (clkEn),
        .wrEn   (state_r == IND_ACCESS && !isRead),
        .addr   (indAddr_r[c][AW-1:0]),
        .wrData (indData_r[c]),
        .rdData (memRd)
      );
    end
  endgenerate

  // ============================================================
  // Stream path selection
  logic rxGen, txIns, rxExt, insSlot, detSlot, rxSrc, genBit, detBit, expBit, txNext;
  assign rxGen   = testSel_r[`BIT_RX_PAT_GEN];
  assign txIns   = pcCtrl_r[1][`BIT_BLOCK_ENABLE] && slotMask[1][slotIdx];
  assign rxExt   = pcCtrl_r[0][`BIT_BLOCK_ENABLE] && slotMask[0][slotIdx];
  // Loopback takes the bit leaving now, so detection stays in its own slot
  assign txNext  = (insSlot && !rxGen) ? genBit : txBitIn;               // [RULE1]
  assign rxSrc   = loop_r[`BIT_LOOP_DIAG] ? txNext : rxBitIn;            // [RULE6]
  // Line test: insert on transmit, check receive; backplane test: swapped
  assign insSlot = rxGen ? rxExt : txIns;                                // [RULE17]
  assign detSlot = rxGen ? txIns : rxExt;                                // [RULE17]
  assign detBit  = rxGen ? txBitIn : rxSrc;
  assign genBit  = gen_r[0] ^ errPend_r;                                 // [RULE15]
  assign expBit  = patCtrl_r[`BIT_REPETITIVE] ? det_r[lenIdx]
                                              : det_r[lenIdx] ^ det_r[fbIdx];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txOut_r <= 1'b0;
      rxOut_r <= 1'b0;
    end else if (clkEn && slotBitEn) begin
      txOut_r <= txNext;                                                 // [RULE1]
      rxOut_r <= (insSlot && rxGen) ? genBit : rxSrc;
    end
  end

  // ============================================================
  // Generator
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gen_r <= '0;
    end else if (wr && regAddr == `REG_INS_LAST) begin
      gen_r <= {regWrData, insReg_r[2], insReg_r[1], insReg_r[0]};      // [RULE5]
    end else if (clkEn && slotBitEn && insSlot) begin
      gen_r <= gen_r >> 1;
      gen_r[lenIdx] <= patCtrl_r[`BIT_REPETITIVE] ? gen_r[0]
                                                  : gen_r[0] ^ gen_r[tapIdx]; // [RULE3] [RULE4]
    end
  end

  // One error per 0-to-1 edge of the inject bit, spent on the next bit out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      errPend_r <= 1'b0;
    end else if (wr && regAddr == `REG_ERR_INS && regWrData[`BIT_ERR_INJECT]
                 && !errIns_r[`BIT_ERR_INJECT]) begin
      errPend_r <= 1'b1;                                                 // [RULE15]
    end else if (clkEn && slotBitEn && insSlot) begin
      errPend_r <= 1'b0;
    end
  end

  // ============================================================
  // Detector
  logic detStep, miss;
  assign detStep = clkEn && slotBitEn && detSlot;
  assign miss    = detStep && (detBit != expBit);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      det_r       <= '0;
      syncValid_r <= 1'b0;
      matchCnt_r  <= '0;
      missCnt_r   <= '0;
    end else if (detStep) begin
      // In sync the reference runs free, so one bad bit counts once
      det_r <= {det_r[30:0], syncValid_r ? expBit : detBit};
      if (!syncValid_r) begin
        matchCnt_r <= miss ? 6'h00 : matchCnt_r + 6'h01;
        if (!miss && matchCnt_r == `SYNC_MATCHES - 6'h01) begin
          syncValid_r <= 1'b1;
        end
      end else begin
        missCnt_r <= miss ? missCnt_r + 4'h1 : 4'h0;
        if (miss && missCnt_r == `RESYNC_ERRORS - 4'h1
            && patCtrl_r[`BIT_AUTO_RESYNC]) begin
          syncValid_r <= 1'b0;                                           // [RULE2]
          matchCnt_r  <= '0;
          missCnt_r   <= '0;
        end
      end
    end
  end

  // Running in-sync count of errors, or of all checked bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r      <= '0;
      cntLatch_r <= '0;
    end else if (clkEn) begin
      if (wr && regAddr == `REG_CNT_FIRST) begin
        cntLatch_r <= cnt_r;                                             // [RULE16]
        cnt_r      <= '0;
      end else if (detStep && syncValid_r
                   && (miss || !patCtrl_r[`BIT_CNT_ERRORS])) begin
        cnt_r <= cnt_r + 32'h1;                                          // [RULE2]
      end
    end
  end

  // Bit-error indication holds until read; a new error wins over the read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitErrInd_r <= 1'b0;
    end else if (miss && syncValid_r) begin
      bitErrInd_r <= 1'b1;                                               // [RULE13]
    end else if (rd && regAddr == `REG_PAT_STAT) begin
      bitErrInd_r <= 1'b0;
    end
  end

  // ============================================================
  // Interrupts
  logic       syncPrev_r;
  logic [7:0] irqSet;
  always_comb begin
    irqSet = 8'h00;
    irqSet[`IRQ_SYNC_CHANGE] = syncValid_r != syncPrev_r;
    irqSet[`IRQ_BIT_ERROR]   = miss && syncValid_r;
    irqSet[`IRQ_IND_DONE]    = |indDone;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncPrev_r <= 1'b0;
      irqStat_r  <= `RESET_BYTE;
    end else if (clkEn) begin
      syncPrev_r <= syncValid_r;
      if (regWrEn && regAddr == `REG_IRQ_STATUS) begin
        irqStat_r <= (irqStat_r & ~regWrData) | irqSet;
      end else begin
        irqStat_r <= irqStat_r | irqSet;
      end
    end
  end

  // ============================================================
  // Read port
  byte_t rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (regAddr == `REG_TEST_SEL) begin
      rdMux = testSel_r;
    end else if (regAddr == `REG_SIGBUF_CTRL) begin
      rdMux = sigCtrl_r;
    end else if (regAddr == `REG_SIGBUF_STAT) begin
      rdMux = 8'h00;
    end else if (regAddr == `REG_RXPC_CTRL) begin
      rdMux = pcCtrl_r[0];
    end else if (regAddr == `REG_RXPC_STAT) begin
      rdMux = {busy[0], 7'h00};                                          // [RULE12]
    end else if (regAddr == `REG_TXPC_CTRL) begin
      rdMux = pcCtrl_r[1];
    end else if (regAddr == `REG_TXPC_STAT) begin
      rdMux = {busy[1], 7'h00};                                          // [RULE12]
    end else if (regAddr == `REG_PAT_CTRL) begin
      rdMux = patCtrl_r;
    end else if (regAddr == `REG_PAT_STAT) begin
      rdMux[`BIT_SYNC_VALID] = syncValid_r;                              // [RULE13]
      rdMux[`BIT_BIT_ERROR]  = bitErrInd_r;
    end else if (regAddr == `REG_PAT_LEN) begin
      rdMux = patLen_r;
    end else if (regAddr == `REG_PAT_TAP) begin
      rdMux = patTap_r;
    end else if (regAddr == `REG_ERR_INS) begin
      rdMux = errIns_r;
    end else if (regAddr >= `REG_INS_FIRST && regAddr < `REG_INS_LAST) begin
      rdMux = insReg_r[regAddr[1:0]];
    end else if (regAddr == `REG_INS_LAST) begin
      rdMux = gen_r[31:24];
    end else if (regAddr >= `REG_CNT_FIRST && regAddr <= `REG_CNT_LAST) begin
      rdMux = cntLatch_r[8*regAddr[1:0] +: 8];                           // [RULE16]
    end else if (regAddr == `REG_LOOPBACK) begin
      rdMux = loop_r;
    end else if (regAddr == `REG_RX_ACC_EN) begin
      rdMux = accEn_r[0];
    end else if (regAddr == `REG_RX_IND_ADDR) begin
      rdMux = indAddr_r[0];
    end else if (regAddr == `REG_RX_IND_DATA) begin
      rdMux = indData_r[0];
    end else if (regAddr == `REG_TX_ACC_EN) begin
      rdMux = accEn_r[1];
    end else if (regAddr == `REG_TX_IND_ADDR) begin
      rdMux = indAddr_r[1];
    end else if (regAddr == `REG_TX_IND_DATA) begin
      rdMux = indData_r[1];
    end else if (regAddr == `REG_IRQ_STATUS) begin
      rdMux = irqStat_r;
    end else if (regAddr == `REG_IRQ_MASK) begin
      rdMux = irqMask_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData_r <= `RESET_BYTE;
    end else if (clkEn) begin
      rdData_r <= regRdEn ? rdMux : 8'h00;
    end
  end

  // ============================================================
  // Outputs
  logic [2:0] framerSel_r;
  logic       loopDiag_r, irq_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      framerSel_r <= 3'h0;
      loopDiag_r  <= 1'b0;
      irq_r       <= 1'b0;
    end else if (clkEn) begin
      framerSel_r <= testSel_r[`FRAMER_SEL_LSB +: 3];                    // [RULE1]
      loopDiag_r  <= loop_r[`BIT_LOOP_DIAG];                             // [RULE6]
      irq_r       <= |(irqStat_r & irqMask_r);
    end
  end

  assign regRdData    = rdData_r;
  assign txBitOut     = txOut_r;
  assign rxBitOut     = rxOut_r;
  assign framerSel    = framerSel_r;
  assign loopbackDiag = loopDiag_r;
  assign irq          = irq_r;
endmodule : prbs_test_path

/* test/far_end_loop.sv */
/*
  Far end of the line, looping each transmit bit back.
  Assumes one line bit for each stream strobe.
*/
module far_end_loop (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Line
  input  wire logic bitEn,
  input  wire logic txLine,
  output logic      rxLine
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxLine <= 1'b0;
    end else if (bitEn) begin
      rxLine <= txLine;
    end
  end
endmodule : far_end_loop

/* test/prbs_test_path_props.sv */
/*
  Port checker of the pattern test path.
  Assumes the bind at the foot of this file.
*/
module prbs_test_path_props (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 clkEn,
  // Register port
  input wire logic [7:0]           regAddr,
  input wire prbs_test_pkg::byte_t regWrData,
  input wire logic                 regWrEn,
  input wire logic                 regRdEn,
  input wire prbs_test_pkg::byte_t regRdData,
  // Stream and status
  input wire logic                 slotBitEn,
  input wire logic                 txBitOut,
  input wire logic                 rxBitOut,
  input wire logic [2:0]           framerSel,
  input wire logic                 loopbackDiag,
  input wire logic                 irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import prbs_test_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_framer;
    clkEn && regWrEn && regAddr == 8'h0C |=> ##1 framerSel == $past(regWrData[7:5], 2);
  endproperty
  a_framer: assert property (p_framer) else $error("framer select");
  property p_loop;
    clkEn && regWrEn && regAddr == 8'h87 |=> ##1 loopbackDiag == $past(regWrData[2], 2);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback");
  property p_readback;
    clkEn && regWrEn && regAddr inside {8'h72, 8'h73} ##1 !regWrEn
      ##1 regRdEn && regAddr == $past(regAddr, 2) |=> regRdData == $past(regWrData, 3);
  endproperty
  a_readback: assert property (p_readback) else $error("readback");
  property p_rd_idle;
    clkEn && !regRdEn |=> regRdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
  property p_unmapped;
    clkEn && regRdEn && regAddr == 8'h01 |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_tx_hold;
    clkEn && !slotBitEn |=> $stable(txBitOut);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx bit moved");
  property p_rx_hold;
    clkEn && !slotBitEn |=> $stable(rxBitOut);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx bit moved");
  property p_irq_mask;
    clkEn && regWrEn && regAddr == 8'hF1 && regWrData == 8'h00 |=> ##1 !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
endmodule : prbs_test_path_props

bind prbs_test_path prbs_test_path_props i_props (
  .clk(clk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .slotBitEn(slotBitEn), .txBitOut(txBitOut),
  .rxBitOut(rxBitOut), .framerSel(framerSel), .loopbackDiag(loopbackDiag), .irq(irq)
);

/* test/prbs_test_path_test.sv */
/*
  Self-checking bench of the pattern test path.
  Assumes design, checker and loop model are compiled first.
*/
module prbs_test_path_test;
  timeunit 1ns;
  timeprecision 1ps;
  import prbs_test_pkg::*;
  logic       clk = 1'b0, resetn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic       slotBitEn = 1'b0, txBitIn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  byte_t      regWrData = 8'h00;
  logic [4:0] slotIdx = 5'h00;
  logic [1:0] phase = 2'h0;
  byte_t      regRdData, rd;
  logic       rxBitIn, txBitOut, rxBitOut, loopbackDiag, irq;
  logic [2:0] framerSel;
  int         n_fail = 0;
  int         samples_checked = 0;
  prbs_test_path i_dut (
    .clk(clk), .resetn(resetn), .clkEn(1'b1), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .slotIdx(slotIdx), .slotBitEn(slotBitEn), .txBitIn(txBitIn), .rxBitIn(rxBitIn),
    .txBitOut(txBitOut), .rxBitOut(rxBitOut), .framerSel(framerSel),
    .loopbackDiag(loopbackDiag), .irq(irq)
  );
  far_end_loop i_loop (
    .clk(clk), .resetn(resetn), .bitEn(slotBitEn), .txLine(txBitOut), .rxLine(rxBitIn)
  );
  initial begin
    forever #5 clk = ~clk;
  end
  // One stream bit every fourth cycle
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    slotBitEn <= (phase == 2'h3);
    if (slotBitEn) begin
      slotIdx <= slotIdx + 5'h01;
      txBitIn <= ~txBitIn;
    end
  end
  // ====================
  // Register port
  task automatic check(input string what, input byte_t seen, input byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rdchk(input byte_t a, input byte_t m, input byte_t e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    rd = regRdData;
    check($sformatf("reg %h", a), rd & m, e);
  endtask : rdchk
  task automatic idle(input byte_t a);
    rdchk(a, 8'h00, 8'h00);
    for (int i = 0; i < 8 && rd[7] !== 1'b0; i++) rdchk(a, 8'h00, 8'h00);
    check("busy", rd & 8'h80, 8'h00);
  endtask : idle
  task automatic iw(input logic tx, input byte_t d, input byte_t a);
    wr(tx ? 8'hE3 : 8'hDF, d);
    wr(tx ? 8'hE2 : 8'hDE, a);
    rdchk(tx ? 8'h65 : 8'h61, 8'h80, 8'h80);
    idle(tx ? 8'h65 : 8'h61);
  endtask : iw
  // ====================
  // Scenarios
  task automatic t_config();
    byte_t cfg [5][2];
    cfg = '{'{8'h0C, 8'h20}, '{8'h70, 8'h82}, '{8'h72, 8'h18}, '{8'h73, 8'h02}, '{8'h87, 8'h04}};
    foreach (cfg[i]) begin
      wr(cfg[i][0], cfg[i][1]);
      rdchk(cfg[i][0], 8'hFF, cfg[i][1]);
    end
    rdchk(8'h01, 8'hFF, 8'h00);
    check("framerSel", {5'h00, framerSel}, 8'h01);
    check("loopbackDiag", {7'h00, loopbackDiag}, 8'h01);
  endtask : t_config
  task automatic t_indirect();
    byte_t slots [3];
    slots = '{8'h22, 8'h24, 8'h25};
    wr(8'hE0, 8'h01);
    wr(8'hE2, 8'h22);
    rdchk(8'h65, 8'h80, 8'h00);
    wr(8'h64, 8'h01);
    wr(8'h60, 8'h01);
    wr(8'h5C, 8'h01);
    wr(8'hDC, 8'h01);
    for (int i = 8'h20; i < 8'h80; i++) begin
      if (i < 8'h40) iw(1'b0, 8'h00, 8'(i));
      if (i < 8'h40 || i >= 8'h60) iw(1'b1, 8'h00, 8'(i));
    end
    foreach (slots[k]) begin
      iw(1'b1, 8'h08, slots[k]);
      iw(1'b0, 8'h80, slots[k]);
    end
    wr(8'hE2, 8'hA2);
    idle(8'h65);
    rdchk(8'hE3, 8'hFF, 8'h08);
    wr(8'hDE, 8'hA2);
    idle(8'h61);
    rdchk(8'hDF, 8'hFF, 8'h80);
  endtask : t_indirect
  task automatic t_sync();
    for (int i = 8'h78; i < 8'h7C; i++) wr(8'(i), 8'hFF);
    repeat (4000) @(posedge clk);
    rdchk(8'h71, 8'h00, 8'h00);
    rdchk(8'h71, 8'h14, 8'h10);
    check("rxBitOut", {7'h00, rxBitOut}, {7'h00, txBitOut});
  endtask : t_sync
  task automatic t_errors();
    wr(8'h7C, 8'h00);
    repeat (3) begin
      wr(8'h74, 8'h08);
      wr(8'h74, 8'h00);
      repeat (200) @(posedge clk);
    end
    rdchk(8'h71, 8'h14, 8'h14);
    wr(8'h7C, 8'h00);
    for (int i = 0; i < 4; i++) rdchk(8'h7C + 8'(i), 8'hFF, i == 0 ? 8'h03 : 8'h00);
  endtask : t_errors
  task automatic t_irq();
    byte_t seq [4];
    seq = '{8'h04, 8'h00, 8'h04, 8'h04};
    wr(8'hF0, 8'hFF);
    wr(8'hE2, 8'hA2);
    idle(8'h65);
    foreach (seq[i]) begin
      wr(i == 3 ? 8'hF0 : 8'hF1, seq[i]);
      repeat (2) @(posedge clk);
      #1 check("irq", {7'h00, irq}, {7'h00, i[0] == 1'b0 && i != 3});
    end
  endtask : t_irq
  task automatic t_backplane();
    wr(8'h0C, 8'h24);
    rdchk(8'h0C, 8'hFF, 8'h24);
    check("framerSel", {5'h00, framerSel}, 8'h01);
  endtask : t_backplane
  task automatic results();
    $display("Checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    #500us;
    n_fail++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_config();
    t_indirect();
    t_sync();
    t_errors();
    t_irq();
    t_backplane();
    results();
  end
endmodule : prbs_test_path_test
